/* File: flash_pe_pkg.sv */
`default_nettype none
package flash_pe_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] CTRL_INDEX = 12'h0f7;
  localparam logic [11:0] MCFG_INDEX = 12'h0f8;
  localparam logic [11:0] LSTAT_INDEX = 12'h0f9;
  localparam logic [11:0] CTRL_ADDR = {CTRL_INDEX[9:0], 2'b00};
  localparam logic [11:0] MCFG_ADDR = {MCFG_INDEX[9:0], 2'b00};
  localparam logic [11:0] LSTAT_ADDR = {LSTAT_INDEX[9:0], 2'b00};

  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [1:0] MCFG_RESET = 2'h2;

  // array occupies the upper half of the 64k space, top 8k is boot
  localparam logic [15:0] BOOT_BASE = 16'he000;
  localparam logic [13:0] BOOT_WORD_IDX = 14'h3000;
  localparam logic [13:0] LAST_WORD_IDX = 14'h3fff;
  localparam int ARRAY_WORDS = 16384;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic halt_clock_in_wait;
    logic prog_voltage_ok;
    logic bulk_clear_select;
    logic capture_arm;
    logic hv_apply;
  } ctrl_t;

  typedef struct packed {
    logic protect_top_block;
    logic multi_word_program;
  } mcfg_t;

  typedef struct packed {
    logic write;
    logic byte_size_access;
    logic [15:0] addr;
    logic [15:0] wdata;
  } arr_req_t;

  typedef struct packed {
    logic ignored;
    logic [15:0] rdata;
  } arr_rsp_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RD_MIS, ST_PROG_A, ST_PROG_B, ST_SWEEP} seq_state_t;

endpackage : flash_pe_pkg
`default_nettype wire

/* File: flash_cell_array.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_cell_array (
  // clock
  input wire logic aclk,
  // read port
  input wire logic [13:0] rd_idx,
  output logic [15:0] rd_word,
  // program / erase port
  input wire logic wr_en,
  input wire logic wr_erase,
  input wire logic [13:0] wr_idx,
  input wire logic [15:0] wr_and
);
  import flash_pe_pkg::*;

  // no reset: cells are nonvolatile
  logic [15:0] cells [ARRAY_WORDS];

  assign rd_word = cells[rd_idx];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      cells[wr_idx] <= wr_erase ? ERASED_WORD : (cells[wr_idx] & wr_and);
    end
  end

endmodule : flash_cell_array
`default_nettype wire

/* File: flash_program_erase_control.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // array access from cpu
  input wire logic arr_valid,
  output logic arr_ready,
  input wire flash_pe_pkg::arr_req_t arr_req,
  output logic arr_done,
  output flash_pe_pkg::arr_rsp_t arr_rsp,
  // chip side
  input wire logic high_volt_pin,
  input wire logic wait_mode,
  output logic flash_clk_en,
  output logic hv_switch
);
  import flash_pe_pkg::*;

  ctrl_t ctrl_r, ctrl_nxt, wd;
  mcfg_t mcfg_r;
  seq_state_t st_r;
  logic vok_r, loaded_r, hv_d_r, lat_byte_r;
  logic [15:0] lat_addr_r, lat_data_r;
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r, rd_mux;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_fire, ctrl_wr, mcfg_wr, rd_hit, hv_start, flash_run, accept, capture;
  logic arr_done_r, prot_hit;
  arr_rsp_t arr_rsp_r;
  logic [13:0] rd_idx, wr_idx, mis_idx_r, sweep_idx_r;
  logic [15:0] rd_word, wr_and;
  logic [7:0] mis_hi_r;
  logic wr_en, wr_erase, arm, hv, ers;

  assign arm = ctrl_r.capture_arm;
  assign hv = ctrl_r.hv_apply;
  assign ers = ctrl_r.bulk_clear_select;

  // ---------------- axi4-lite slave ----------------
  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign ctrl_wr = wr_fire && (aw_addr_r == CTRL_ADDR) && w_strb_r[0];
  assign mcfg_wr = wr_fire && (aw_addr_r == MCFG_ADDR) && w_strb_r[0];
  assign wd = ctrl_t'(w_data_r[4:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (aw_addr_r == CTRL_ADDR || aw_addr_r == MCFG_ADDR ||
                    aw_addr_r == LSTAT_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (araddr)
      CTRL_ADDR: rd_mux = {27'h0, ctrl_r};
      MCFG_ADDR: rd_mux = {30'h0, mcfg_r};
      LSTAT_ADDR: rd_mux = {14'h0, loaded_r, lat_byte_r, lat_addr_r};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------- control register ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vok_r <= 1'b0;
    end else begin
      vok_r <= high_volt_pin;
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    ctrl_nxt.prog_voltage_ok = vok_r;
    if (ctrl_wr) begin
      if (hv) begin
        ctrl_nxt.hv_apply = wd.hv_apply;
      end else begin
        ctrl_nxt.halt_clock_in_wait = wd.halt_clock_in_wait;
        ctrl_nxt.bulk_clear_select = wd.bulk_clear_select;
        // setting needs voltage, clearing never blocked
        ctrl_nxt.capture_arm = wd.capture_arm && (arm || vok_r);
        // same-write arm clear refuses hv so nothing is programmed
        ctrl_nxt.hv_apply = wd.hv_apply && wd.capture_arm && arm && loaded_r;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= ctrl_t'(CTRL_RESET);
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcfg_r <= mcfg_t'(MCFG_RESET);
    end else if (mcfg_wr) begin
      mcfg_r.multi_word_program <= w_data_r[0];
      if (!hv) begin
        mcfg_r.protect_top_block <= w_data_r[1];
      end
    end
  end

  // capture beats the arm clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loaded_r <= 1'b0;
    end else if (capture) begin
      loaded_r <= 1'b1;
    end else if (!ctrl_nxt.capture_arm) begin
      loaded_r <= 1'b0;
    end
  end

  // ---------------- array access ----------------
  assign flash_run = !(wait_mode && ctrl_r.halt_clock_in_wait);
  assign flash_clk_en = flash_run;
  assign hv_switch = hv && flash_run;
  assign hv_start = hv && !hv_d_r;
  assign arr_ready = (st_r == ST_IDLE) && !hv_start;
  assign accept = arr_valid && arr_ready;
  assign capture = accept && arr_req.write && arm && !loaded_r && !hv && arr_req.addr[15];
  assign arr_done = arr_done_r;
  assign arr_rsp = arr_rsp_r;
  assign rd_idx = (st_r == ST_RD_MIS) ? mis_idx_r : arr_req.addr[14:1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_addr_r <= 16'h0000;
      lat_data_r <= 16'h0000;
      lat_byte_r <= 1'b0;
    end else if (capture) begin
      lat_addr_r <= arr_req.addr;
      lat_data_r <= arr_req.wdata;
      // a misaligned word shrinks to its first byte
      lat_byte_r <= arr_req.byte_size_access || arr_req.addr[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arr_done_r <= 1'b0;
      arr_rsp_r <= '0;
      mis_idx_r <= 14'h0000;
      mis_hi_r <= 8'h00;
    end else begin
      arr_done_r <= 1'b0;
      if (st_r == ST_RD_MIS) begin
        arr_done_r <= 1'b1;
        arr_rsp_r <= {1'b0, mis_hi_r, rd_word[15:8]};
      end else if (accept) begin
        arr_done_r <= !(!arr_req.write && !hv && !(arm && !ers) && arr_req.addr[15] &&
                        !arr_req.byte_size_access && arr_req.addr[0]);
        arr_rsp_r <= {1'b1, 16'h0000};
        if (arr_req.write) begin
          arr_rsp_r.ignored <= !capture;
        end else if (hv) begin
          arr_rsp_r.ignored <= 1'b1;
        end else if (arm && !ers) begin
          arr_rsp_r <= {1'b0, lat_data_r};
        end else if (arr_req.addr[15]) begin
          if (arr_req.byte_size_access) begin
            arr_rsp_r <= {1'b0, 8'h00, arr_req.addr[0] ? rd_word[7:0] : rd_word[15:8]};
          end else if (!arr_req.addr[0]) begin
            arr_rsp_r <= {1'b0, rd_word};
          end else begin
            mis_hi_r <= rd_word[7:0];
            mis_idx_r <= arr_req.addr[14:1] + 14'h0001;
          end
        end
      end
    end
  end

  // ---------------- program / erase sequencing ----------------
  assign prot_hit = mcfg_r.protect_top_block && (lat_addr_r >= BOOT_BASE);

  always_comb begin
    wr_en = 1'b0;
    wr_erase = 1'b0;
    wr_idx = lat_addr_r[14:1];
    wr_and = lat_data_r;
    if (lat_byte_r) begin
      wr_and = lat_addr_r[0] ? {ERASED_BYTE, lat_data_r[7:0]} : {lat_data_r[7:0], ERASED_BYTE};
    end
    case (st_r)
      ST_PROG_A: begin
        wr_en = !prot_hit;
        if (mcfg_r.multi_word_program) begin
          wr_idx = {lat_addr_r[14:2], 1'b0};
        end
      end
      ST_PROG_B: begin
        wr_en = !prot_hit;
        wr_idx = {lat_addr_r[14:2], 1'b1};
      end
      ST_SWEEP: begin
        wr_erase = 1'b1;
        wr_idx = sweep_idx_r;
        wr_en = flash_run && !(mcfg_r.protect_top_block && sweep_idx_r >= BOOT_WORD_IDX);
      end
      default: wr_en = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hv_d_r <= 1'b0;
    end else begin
      hv_d_r <= hv;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      sweep_idx_r <= 14'h0000;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (hv_start && flash_run) begin
            st_r <= ers ? ST_SWEEP : ST_PROG_A;
            sweep_idx_r <= 14'h0000;
          end else if (accept && !arr_req.write && !hv && !(arm && !ers) && arr_req.addr[15] &&
                       !arr_req.byte_size_access && arr_req.addr[0]) begin
            st_r <= ST_RD_MIS;
          end
        end
        ST_RD_MIS: st_r <= ST_IDLE;
        ST_PROG_A: st_r <= mcfg_r.multi_word_program ? ST_PROG_B : ST_IDLE;
        ST_PROG_B: st_r <= ST_IDLE;
        ST_SWEEP: begin
          // dropping the high voltage ends the sweep; the current word is still erased in that cycle
          if (!hv || (flash_run && sweep_idx_r == LAST_WORD_IDX)) begin
            st_r <= ST_IDLE;
          end else if (flash_run) begin
            sweep_idx_r <= sweep_idx_r + 14'h0001;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  flash_cell_array u_cells (
    .aclk(aclk),
    .rd_idx(rd_idx),
    .rd_word(rd_word),
    .wr_en(wr_en),
    .wr_erase(wr_erase),
    .wr_idx(wr_idx),
    .wr_and(wr_and)
  );

  // ---------------- assertions ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_hv_needs_latch: assert property ($rose(hv) |-> $past(arm) && $past(loaded_r))
    else $error("hv applied without loaded latches");
  a_hv_freezes_cfg: assert property (hv && $past(hv) |-> $stable(arm) && $stable(ers) &&
    $stable(mcfg_r.protect_top_block))
    else $error("locked bits changed under high voltage");
  a_arm_needs_volt: assert property ($rose(arm) |-> $past(vok_r))
    else $error("arm set without programming voltage");
  a_read_hv_ignored: assert property (accept && !arr_req.write && hv |=> arr_done_r &&
    arr_rsp_r.ignored)
    else $error("array read not ignored under high voltage");
  a_read_latched: assert property (accept && !arr_req.write && !hv && arm && !ers |=>
    arr_rsp_r.rdata == $past(lat_data_r))
    else $error("armed read did not return latched data");
  a_write_locked: assert property (accept && arr_req.write && loaded_r |=> arr_rsp_r.ignored &&
    $stable(lat_addr_r) && $stable(lat_data_r))
    else $error("array write changed loaded latches");
  a_wait_halts: assert property (wait_mode && ctrl_r.halt_clock_in_wait && st_r == ST_SWEEP &&
    hv |=> $stable(sweep_idx_r))
    else $error("erase advanced with clock halted");
  a_misaligned_two: assert property (accept && !arr_req.write && !hv && !(arm && !ers) &&
    arr_req.addr[15] && !arr_req.byte_size_access && arr_req.addr[0] |=> !arr_done_r ##1 arr_done_r)
    else $error("misaligned read not two cycles");
  a_aligned_one: assert property (accept && !arr_req.write && arr_req.addr[15] &&
    !arr_req.addr[0] |=> arr_done_r)
    else $error("aligned read not one cycle");
  a_multi_pair: assert property (st_r == ST_PROG_A && mcfg_r.multi_word_program |-> !wr_idx[0]
    ##1 st_r == ST_PROG_B && wr_idx[0])
    else $error("multi-word program skipped a word");
  a_ctrl_upper_zero: assert property (arvalid && arready && araddr == CTRL_ADDR |=>
    rdata_r[31:5] == 27'h0)
    else $error("control upper bits not zero");
  // a capture in the clearing cycle wins, so the flag may lag by one cycle
  a_loaded_clear: assert property ($fell(arm) |-> !loaded_r || $past(capture))
    else $error("loaded flag survived arm clear");

  c_capture: cover property (capture ##[1:20] $rose(hv));
  c_program_pair: cover property (st_r == ST_PROG_A ##1 st_r == ST_PROG_B);
  c_erase_sweep: cover property (st_r == ST_SWEEP && sweep_idx_r == BOOT_WORD_IDX);
  c_misaligned: cover property (st_r == ST_RD_MIS);

endmodule : flash_program_erase_control
`default_nettype wire

/* File: cpu_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_array_model (
  // clock
  input wire logic aclk,
  // array port
  output logic arr_valid,
  input wire logic arr_ready,
  output flash_pe_pkg::arr_req_t arr_req,
  input wire logic arr_done,
  input wire flash_pe_pkg::arr_rsp_t arr_rsp
);
  import flash_pe_pkg::*;
  initial begin
    arr_valid = 1'b0;
    arr_req = '0;
  end
  // one access outstanding; caller enters just after a rising edge
  task automatic access(input logic wr, input logic bsz, input logic [15:0] a,
      input logic [15:0] d, output arr_rsp_t r, output int lat);
    bit acc;
    bit seen;
    int k;
    int n;
    acc = 0;
    k = 0;
    lat = -1;
    r = '0;
    arr_req <= '{write: wr, byte_size_access: bsz, addr: a, wdata: d};
    arr_valid <= 1'b1;
    for (n = 0; n < 400 && lat < 0; n++) begin
      @(negedge aclk);
      if (acc) k++;
      if (acc && arr_done) begin
        lat = k;
        r = arr_rsp;
      end
      seen = arr_valid && arr_ready;
      @(posedge aclk);
      if (seen) begin
        acc = 1;
        arr_valid <= 1'b0;
        // released request lines do not keep the old value
        arr_req <= ~arr_req;
      end
    end
  endtask : access
endmodule : cpu_array_model
`default_nettype wire

/* File: flash_program_erase_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control_tb_top;
  import flash_pe_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, arr_valid, arr_ready, arr_done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  arr_req_t arr_req;
  arr_rsp_t arr_rsp;
  logic high_volt_pin = 0;
  logic wait_mode = 0;
  logic flash_clk_en, hv_switch;
  int miscompares = 0;
  int compares = 0;

  always #2.5 aclk = ~aclk;

  flash_program_erase_control dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .arr_valid, .arr_ready, .arr_req, .arr_done,
    .arr_rsp, .high_volt_pin, .wait_mode, .flash_clk_en, .hv_switch);

  cpu_array_model cpu (.aclk, .arr_valid, .arr_ready, .arr_req, .arr_done, .arr_rsp);

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ta;
    bit tw;
    bit tb;
    logic [1:0] r;
    tb = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 100 && !tb; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 0;
        awaddr <= ~a;
      end
      if (tw) begin
        wvalid <= 0;
        wdata <= ~d;
      end
    end
    chk({29'h0, tb, r}, {29'h0, 1'b1, er}, "write response");
  endtask : axw

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er,
      input string m);
    bit ta;
    bit tr;
    logic [31:0] d;
    logic [1:0] r;
    tr = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 100 && !tr; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) begin
        arvalid <= 0;
        araddr <= ~a;
      end
    end
    chk({29'h0, tr, r}, {29'h0, 1'b1, er}, "read response");
    if (er == RESP_OKAY) chk(d, e, m);
  endtask : rdc

  // array access; data compared only when cd is set, byte reads in the low byte
  task automatic ac(input logic wr, input logic bsz, input logic [15:0] a, input logic [15:0] d,
      input logic ei, input logic [15:0] ed, input int el, input bit cd);
    arr_rsp_t r;
    int lat;
    cpu.access(wr, bsz, a, d, r, lat);
    chk({31'h0, r.ignored}, {31'h0, ei}, "array ignored flag");
    if (cd) chk({16'h0, r.rdata & (bsz ? 16'h00ff : 16'hffff)}, {16'h0, ed}, "array data");
    chk(32'(lat), 32'(el), "array latency");
  endtask : ac

  // arm, load latches, pulse once, disarm
  task automatic prog(input logic bsz, input logic [15:0] a, input logic [15:0] d);
    axw(CTRL_ADDR, 32'h02, RESP_OKAY);
    ac(1, bsz, a, d, 0, 16'h0, 1, 0);
    axw(CTRL_ADDR, 32'h03, RESP_OKAY);
    rdc(CTRL_ADDR, 32'h0b, RESP_OKAY, "ctrl during pulse");
    axw(CTRL_ADDR, 32'h02, RESP_OKAY);
    axw(CTRL_ADDR, 32'h00, RESP_OKAY);
  endtask : prog

  initial begin
    repeat (45000) @(posedge aclk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rdc(CTRL_ADDR, 32'h0, RESP_OKAY, "ctrl reset value");
    rdc(12'h000, 32'h0, RESP_SLVERR, "unmapped");
    axw(CTRL_ADDR, 32'hff, RESP_OKAY);
    rdc(CTRL_ADDR, 32'h14, RESP_OKAY, "ctrl without voltage");
    wait_mode <= 1;
    @(negedge aclk);
    chk({31'h0, flash_clk_en}, 32'h0, "clock halted in wait");
    @(posedge aclk);
    axw(CTRL_ADDR, 32'h04, RESP_OKAY);
    chk({31'h0, flash_clk_en}, 32'h1, "clock runs in wait");
    wait_mode <= 0;
    high_volt_pin <= 1;
    axw(MCFG_ADDR, 32'h0, RESP_OKAY);
    axw(CTRL_ADDR, 32'h16, RESP_OKAY);
    rdc(CTRL_ADDR, 32'h1e, RESP_OKAY, "erase armed");
    axw(CTRL_ADDR, 32'h17, RESP_OKAY);
    rdc(CTRL_ADDR, 32'h1e, RESP_OKAY, "hv before latch");
    ac(1, 0, 16'h8000, 16'h0, 0, 16'h0, 1, 0);
    ac(1, 0, 16'h8002, 16'h0, 1, 16'h0, 1, 0);
    axw(CTRL_ADDR, 32'h17, RESP_OKAY);
    chk({31'h0, hv_switch}, 32'h1, "hv switch on");
    // halted clock in wait stalls the sweep and drops the switch
    wait_mode <= 1;
    repeat (3) @(posedge aclk);
    chk({31'h0, hv_switch}, 32'h0, "hv switch off in wait");
    wait_mode <= 0;
    axw(CTRL_ADDR, 32'h11, RESP_OKAY);
    rdc(CTRL_ADDR, 32'h1f, RESP_OKAY, "locked under hv");
    axw(MCFG_ADDR, 32'h2, RESP_OKAY);
    rdc(MCFG_ADDR, 32'h0, RESP_OKAY, "protect locked under hv");
    repeat (16500) @(posedge aclk);
    axw(CTRL_ADDR, 32'h06, RESP_OKAY);
    ac(0, 0, 16'h8000, 16'h0, 0, 16'hffff, 1, 1);
    ac(0, 0, 16'hfffe, 16'h0, 0, 16'hffff, 1, 1);
    axw(CTRL_ADDR, 32'h00, RESP_OKAY);
    axw(CTRL_ADDR, 32'h02, RESP_OKAY);
    ac(1, 0, 16'h8004, 16'h1234, 0, 16'h0, 1, 0);
    rdc(LSTAT_ADDR, 32'h0002_8004, RESP_OKAY, "latch status");
    ac(0, 0, 16'h8004, 16'h0, 0, 16'h1234, 1, 1);
    axw(CTRL_ADDR, 32'h03, RESP_OKAY);
    ac(0, 0, 16'h8004, 16'h0, 1, 16'h0, 1, 0);
    axw(CTRL_ADDR, 32'h02, RESP_OKAY);
    axw(CTRL_ADDR, 32'h00, RESP_OKAY);
    ac(0, 0, 16'h8004, 16'h0, 0, 16'h1234, 1, 1);
    ac(0, 1, 16'h8004, 16'h0, 0, 16'h0012, 1, 1);
    ac(0, 1, 16'h8005, 16'h0, 0, 16'h0034, 1, 1);
    ac(0, 0, 16'h8003, 16'h0, 0, 16'hff12, 2, 1);
    ac(1, 0, 16'h8004, 16'h0, 1, 16'h0, 1, 0);
    prog(1, 16'h8011, 16'h5a5a);
    ac(0, 0, 16'h8010, 16'h0, 0, 16'hff5a, 1, 1);
    prog(0, 16'h8004, 16'h00ff);
    ac(0, 0, 16'h8004, 16'h0, 0, 16'h0034, 1, 1);
    axw(MCFG_ADDR, 32'h1, RESP_OKAY);
    prog(0, 16'h8022, 16'ha5c3);
    ac(0, 0, 16'h8020, 16'h0, 0, 16'ha5c3, 1, 1);
    ac(0, 0, 16'h8022, 16'h0, 0, 16'ha5c3, 1, 1);
    axw(MCFG_ADDR, 32'h2, RESP_OKAY);
    prog(0, 16'he000, 16'h0000);
    ac(0, 0, 16'he000, 16'h0, 0, 16'hffff, 1, 1);
    prog(0, 16'hdffe, 16'h0000);
    ac(0, 0, 16'hdffe, 16'h0, 0, 16'h0000, 1, 1);
    axw(CTRL_ADDR, 32'h02, RESP_OKAY);
    ac(1, 0, 16'h8030, 16'h0, 0, 16'h0, 1, 0);
    axw(CTRL_ADDR, 32'h01, RESP_OKAY);
    rdc(CTRL_ADDR, 32'h08, RESP_OKAY, "hv with arm clear");
    ac(0, 0, 16'h8030, 16'h0, 0, 16'hffff, 1, 1);
    axw(CTRL_ADDR, 32'h02, RESP_OKAY);
    axw(CTRL_ADDR, 32'h03, RESP_OKAY);
    rdc(CTRL_ADDR, 32'h0a, RESP_OKAY, "loaded cleared");
    // bulk erase with the boot block protected keeps a programmed boot word
    axw(MCFG_ADDR, 32'h0, RESP_OKAY);
    prog(0, 16'he000, 16'h0000);
    axw(MCFG_ADDR, 32'h2, RESP_OKAY);
    axw(CTRL_ADDR, 32'h06, RESP_OKAY);
    ac(1, 0, 16'h8000, 16'h0, 0, 16'h0, 1, 0);
    axw(CTRL_ADDR, 32'h07, RESP_OKAY);
    repeat (16400) @(posedge aclk);
    axw(CTRL_ADDR, 32'h06, RESP_OKAY);
    axw(CTRL_ADDR, 32'h00, RESP_OKAY);
    ac(0, 0, 16'he000, 16'h0, 0, 16'h0000, 1, 1);
    ac(0, 0, 16'hdffe, 16'h0, 0, 16'hffff, 1, 1);
    tally_and_finish();
  end
endmodule : flash_program_erase_control_tb_top
`default_nettype wire
